// file: rtl/word_adder_consts.svh
// constants for the word adder with overflow trap
`ifndef WORD_ADDER_CONSTS_SVH
`define WORD_ADDER_CONSTS_SVH
`define OPCODE_HI        31
`define OPCODE_LO        26
`define SRC_A_HI         25
`define SRC_A_LO         21
`define SRC_B_HI         20
`define SRC_B_LO         16
`define DEST_HI          15
`define DEST_LO          11
`define SHAMT_HI         10
`define SHAMT_LO         6
`define FUNCT_HI         5
`define FUNCT_LO         0
`define OPCODE_SPECIAL   6'h00
`define FUNCT_ADD_TRAP   6'h20
`define FUNCT_ADD_NOTRAP 6'h21
`define REG_ZERO         5'h00
`define WORD_ZERO        32'h0000_0000
`endif

// file: rtl/word_adder_pkg.sv
// types shared by the word adder files
package word_adder_pkg;
    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
    } issue_t;
    typedef struct packed {
        logic        write_en;
        logic [4:0]  dest;
        logic [31:0] data;
        logic        overflow_exc;
        logic        done;
    } result_t;
endpackage

// file: rtl/general_register_file.sv
// 32 x 32 general register file, register zero hardwired
`timescale 1ns/1ps
`default_nettype none
`include "word_adder_consts.svh"
module general_register_file #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 32
) (
    input  wire logic                     ref_clk_in,
    input  wire logic [$clog2(DEPTH)-1:0] rd_a_addr_in,
    input  wire logic [$clog2(DEPTH)-1:0] rd_b_addr_in,
    output logic      [WIDTH-1:0]         rd_a_data_out,
    output logic      [WIDTH-1:0]         rd_b_data_out,
    input  wire logic                     wr_en_in,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
    input  wire logic [WIDTH-1:0]         wr_data_in
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_rd_a;
    logic [WIDTH-1:0] next_rd_b;
    logic             wr_ok;

    always_comb begin
        // zero never stored, so reads of it are forced
        wr_ok = wr_en_in && (wr_addr_in != `REG_ZERO);
        next_rd_a = (rd_a_addr_in == `REG_ZERO) ? `WORD_ZERO
                                               : mem[rd_a_addr_in];
        next_rd_b = (rd_b_addr_in == `REG_ZERO) ? `WORD_ZERO
                                               : mem[rd_b_addr_in];
    end

    always_ff @(posedge ref_clk_in) begin
        if (wr_ok) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_a_data_out <= next_rd_a;
        rd_b_data_out <= next_rd_b;
    end
endmodule
`default_nettype wire

// file: rtl/word_adder_overflow_trap.sv
// add execution unit with overflow trap and general register file
`timescale 1ns/1ps
`default_nettype none
`include "word_adder_consts.svh"
module word_adder_overflow_trap
    import word_adder_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    input  wire issue_t      issue_in,
    output logic             issue_ready_out,
    output result_t          result_out,
    input  wire logic        load_en_in,
    input  wire logic [4:0]  load_addr_in,
    input  wire logic [31:0] load_data_in,
    input  wire logic [4:0]  peek_addr_in,
    output logic [31:0]      peek_data_out
);
    typedef enum logic [1:0] {IDLE, READ, EXEC} state_t;

    localparam int REG_COUNT = 32;
    localparam int WORD_BITS = 32;

    // control group: sequencing and the captured instruction
    state_t      state;
    state_t      next_state;
    logic [31:0] instr;
    logic [31:0] next_instr;
    logic        trap_kind;
    logic        next_trap_kind;

    // result group: one-cycle answer to the issue stage
    result_t     next_result;

    // datapath and register file ports
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic [32:0] sum33;
    logic        ovf;
    logic        is_add;
    logic        take;
    logic [4:0]  rd_a_addr;
    logic [4:0]  rd_b_addr;
    logic        rf_wr;
    logic [4:0]  rf_waddr;
    logic [31:0] rf_wdata;

    // sign-extend to 33 bits; overflow when bits 32 and 31 differ
    function automatic logic [32:0] add33(input logic [31:0] a,
                                          input logic [31:0] b);
        add33 = {a[31], a} + {b[31], b};
    endfunction

    function automatic logic sum_overflows(input logic [32:0] s);
        sum_overflows = (s[32] != s[31]);
    endfunction

    // both add forms share the opcode; function field picks the form
    function automatic logic add_word(input logic [31:0] word);
        logic [5:0] op;
        logic [5:0] fn;
        op = word[`OPCODE_HI:`OPCODE_LO];
        fn = word[`FUNCT_HI:`FUNCT_LO];
        add_word = (op == `OPCODE_SPECIAL)
                && (fn == `FUNCT_ADD_TRAP || fn == `FUNCT_ADD_NOTRAP);
    endfunction

    function automatic logic trap_word(input logic [31:0] word);
        trap_word = (word[`FUNCT_HI:`FUNCT_LO] == `FUNCT_ADD_TRAP);
    endfunction

    // index fields; sources read from both the taken and the held word, dest from the held word only
    function automatic logic [4:0] field_a(input logic [31:0] word);
        field_a = word[`SRC_A_HI:`SRC_A_LO];
    endfunction

    function automatic logic [4:0] field_b(input logic [31:0] word);
        field_b = word[`SRC_B_HI:`SRC_B_LO];
    endfunction

    function automatic logic [4:0] field_dest(input logic [31:0] word);
        field_dest = word[`DEST_HI:`DEST_LO];
    endfunction

    // bits 10..6 are not checked: supplier keeps them zero
    assign is_add = add_word(issue_in.instr);
    assign take   = issue_in.valid && is_add && (state == IDLE);
    // other words are dropped without a stall or an error
    assign issue_ready_out = (state == IDLE);

    assign sum33 = add33(rd_a, rd_b);
    assign ovf   = sum_overflows(sum33);

    // in IDLE the indices come from the word being taken, so the
    // operands stand in rd_a/rd_b right after the taking edge, in READ
    always_comb begin
        if (state == IDLE) begin
            rd_a_addr = field_a(next_instr);
            rd_b_addr = field_b(next_instr);
        end else begin
            rd_a_addr = field_a(instr);
            rd_b_addr = field_b(instr);
        end
    end

    // one write port: a committing add wins over the load port, so a
    // preload in that cycle is lost and must be repeated
    always_comb begin
        if (next_result.done) begin
            rf_wr    = next_result.write_en;
            rf_waddr = next_result.dest;
            rf_wdata = next_result.data;
        end else begin
            rf_wr    = load_en_in;
            rf_waddr = load_addr_in;
            rf_wdata = load_data_in;
        end
    end

    general_register_file #(
        .DEPTH(REG_COUNT),
        .WIDTH(WORD_BITS)
    ) u_regs (
        .ref_clk_in    (ref_clk_in),
        .rd_a_addr_in  (rd_a_addr),
        .rd_b_addr_in  (rd_b_addr),
        .rd_a_data_out (rd_a),
        .rd_b_data_out (rd_b),
        .wr_en_in      (rf_wr),
        .wr_addr_in    (rf_waddr),
        .wr_data_in    (rf_wdata)
    );

    // shadow copy costs a second array but keeps the peek read off
    // the operand ports, so a peek never disturbs an add
    general_register_file #(
        .DEPTH(REG_COUNT),
        .WIDTH(WORD_BITS)
    ) u_shadow (
        .ref_clk_in    (ref_clk_in),
        .rd_a_addr_in  (peek_addr_in),
        .rd_b_addr_in  (`REG_ZERO),
        .rd_a_data_out (peek_data_out),
        .rd_b_data_out (),
        .wr_en_in      (rf_wr),
        .wr_addr_in    (rf_waddr),
        .wr_data_in    (rf_wdata)
    );

    // taking edge captures the word; READ and EXEC are the only stalls
    always_comb begin
        next_state     = state;
        next_instr     = instr;
        next_trap_kind = trap_kind;
        case (state)
            IDLE: begin
                if (take) begin
                    next_instr     = issue_in.instr;
                    next_trap_kind = trap_word(issue_in.instr);
                    next_state     = READ;
                end
            end
            READ: begin
                // operand registers reload from the held instruction
                next_state = EXEC;
            end
            EXEC: begin
                // result registers on this edge, ready for the next take
                next_state = IDLE;
            end
            default: begin
                next_state = IDLE;
            end
        endcase
    end

    // answer is formed only in EXEC; outside it every field is zero
    always_comb begin
        next_result = '0;
        case (state)
            EXEC: begin
                next_result.done = 1'b1;
                next_result.dest = field_dest(instr);
                next_result.data = sum33[31:0];
                if (trap_kind && ovf) begin
                    // raw sum still shown, but the write is dropped
                    next_result.write_en     = 1'b0;
                    next_result.overflow_exc = 1'b1;
                end else begin
                    // non-trapping form ignores overflow entirely
                    next_result.write_en = 1'b1;
                end
            end
            default: begin
                next_result = '0;
            end
        endcase
    end

    // reset clears sequencing and result_out; register contents stay undefined
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state     <= IDLE;
            instr     <= `WORD_ZERO;
            trap_kind <= 1'b0;
        end else begin
            state     <= next_state;
            instr     <= next_instr;
            trap_kind <= next_trap_kind;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            result_out <= '0;
        end else begin
            result_out <= next_result;
        end
    end
endmodule
`default_nettype wire

// file: tb/word_adder_assertions.sv
// port assertions for the word adder
`timescale 1ns/1ps
`default_nettype none
module word_adder_assertions
    import word_adder_pkg::*;
(
    input wire logic        ref_clk_in,
    input wire logic        rstn_in,
    input wire issue_t      issue_in,
    input wire logic        issue_ready_out,
    input wire result_t     result_out,
    input wire logic [4:0]  peek_addr_in,
    input wire logic [31:0] peek_data_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    wire logic is_add = issue_in.instr[31:26] == 6'h00
        && issue_in.instr[5:1] == 5'h10;
    wire logic take = issue_in.valid && issue_ready_out && is_add;
    sequence s_busy; !issue_ready_out [*2]; endsequence
    sequence s_done; result_out.done && issue_ready_out; endsequence
    property p_take; take |=> s_busy ##1 s_done; endproperty
    a_take: assert property (p_take) else $error("late");
    property p_dest;
        take |-> ##3 result_out.dest == $past(issue_in.instr[15:11], 3);
    endproperty
    a_dest: assert property (p_dest) else $error("dest");
    property p_one;
        result_out.done |-> result_out.write_en ^ result_out.overflow_exc;
    endproperty
    a_one: assert property (p_one) else $error("both");
    property p_nt; take && issue_in.instr[0] |-> ##3 (s_done
        and result_out.write_en); endproperty
    a_nt: assert property (p_nt) else $error("nontrap");
    property p_quiet; !result_out.done |-> !result_out.write_en
        && !result_out.overflow_exc; endproperty
    a_quiet: assert property (p_quiet) else $error("stray");
    property p_skip;
        issue_in.valid && issue_ready_out && !is_add |=> issue_ready_out;
    endproperty
    a_skip: assert property (p_skip) else $error("taken");
    property p_zero; peek_addr_in == 5'h00 |=> peek_data_out == 32'h0;
    endproperty
    a_zero: assert property (p_zero) else $error("zero");
endmodule
`default_nettype wire

// file: tb/issue_source.sv
// decode-stage model that offers words to the block
`timescale 1ns/1ps
`default_nettype none
module issue_source
    import word_adder_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        go_in,
    input  wire logic [31:0] word_in,
    input  wire logic        ready_in,
    output var  issue_t      issue_out
);
    initial issue_out = '0;
    always @(posedge ref_clk_in) begin
        // released word inverted so stale data never passes as fresh
        if (issue_out.valid && ready_in) begin
            issue_out.valid <= 1'b0;
            issue_out.instr <= ~issue_out.instr;
        end
        if (go_in) begin
            issue_out.valid <= 1'b1;
            issue_out.instr <= {word_in[31:11], 5'h00,
                                word_in[5:0]};
        end
    end
endmodule
`default_nettype wire

// file: tb/test_word_adder_overflow_trap.sv
// self-checking bench for the word adder
`timescale 1ns/1ps
`default_nettype none
module test_word_adder_overflow_trap
    import word_adder_pkg::*;
;
    logic ref_clk_in = 1'b0, rstn_in = 1'b0, go = 1'b0, ld = 1'b0, rdy;
    logic [4:0] la = 5'h00, pa = 5'h00;
    logic [31:0] ld_d = 32'h0, w = 32'h0, pk;
    issue_t iss;
    result_t res;
    int failures = 0, n_checks = 0;
    always #2.5 ref_clk_in = ~ref_clk_in;
    issue_source src (.ref_clk_in, .go_in(go), .word_in(w),
        .ready_in(rdy), .issue_out(iss));
    word_adder_overflow_trap dut (.ref_clk_in, .rstn_in, .issue_in(iss),
        .issue_ready_out(rdy), .result_out(res), .load_en_in(ld),
        .load_addr_in(la), .load_data_in(ld_d), .peek_addr_in(pa),
        .peek_data_out(pk));
    task chk(input logic ok);
        n_checks++;
        if (!ok) begin
            failures++;
            $display("CHECK FAILED %0t mismatch", $time);
        end
    endtask
    task load(input logic [4:0] a, input logic [31:0] d);
        ld <= 1'h1;
        la <= a;
        ld_d <= d;
        @(posedge ref_clk_in);
    endtask
    task issue(input logic [31:0] word);
        go <= 1'h1;
        w <= word;
        @(posedge ref_clk_in);
        go <= 1'h0;
    endtask
    task add_case(input logic f, input logic [4:0] s, d,
                  input logic [31:0] a, b, exp_sum,
                  input logic exp_ov);
        logic [31:0] exp_reg;
        exp_reg = (d == 5'h00) ? 32'h0 : (exp_ov ? 32'h5a5a_0003 : exp_sum);
        @(posedge ref_clk_in);
        load(d, 32'h5a5a_0003);
        load(s, a);
        load(5'h02, b);
        ld <= 1'h0;
        issue({6'h00, s, 5'h02, d, 5'h00, 5'h10, f});
        for (int i = 0; i < 12 && res.done !== 1'b1; i++) begin
            @(posedge ref_clk_in);
            #1;
        end
        if (res.done !== 1'b1) begin
            failures++;
            close_out();
        end
        chk(res.overflow_exc === exp_ov);
        chk(res.write_en === !exp_ov);
        chk(res.dest === d);
        chk(res.data === exp_sum);
        @(posedge ref_clk_in);
        pa <= d;
        @(posedge ref_clk_in);
        #1;
        chk(pk === exp_reg);
    endtask
    task trap_overflow_up;
        add_case(1'h0, 5'h01, 5'h03, 32'h7fff_ffff,
                 32'h0000_0001, 32'h8000_0000, 1'h1);
    endtask
    task nontrap_overflow;
        add_case(1'h1, 5'h01, 5'h03, 32'h7fff_ffff,
                 32'h0000_0001, 32'h8000_0000, 1'h0);
    endtask
    task trap_overflow_down;
        add_case(1'h0, 5'h01, 5'h03, 32'h8000_0000,
                 32'h8000_0000, 32'h0000_0000, 1'h1);
    endtask
    task trap_wrap_clean;
        add_case(1'h0, 5'h01, 5'h03, 32'hffff_ffff,
                 32'h0000_0001, 32'h0000_0000, 1'h0);
    endtask
    task trap_negative_sum;
        add_case(1'h0, 5'h04, 5'h05, 32'hffff_fffe,
                 32'hffff_fffd, 32'hffff_fffb, 1'h0);
    endtask
    task zero_register;
        add_case(1'h1, 5'h00, 5'h00, 32'hffff_ffff,
                 32'h0000_0007, 32'h0000_0007, 1'h0);
    endtask
    task ignore_case;
        @(posedge ref_clk_in);
        issue({6'h00, 5'h01, 5'h02, 5'h03, 5'h00, 6'h22});
        repeat (6) begin
            @(posedge ref_clk_in);
            #1;
            chk(res.done === 1'b0 && rdy === 1'b1);
        end
    endtask
    task close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_in);
        rstn_in <= 1'h1;
        trap_overflow_up();
        nontrap_overflow();
        trap_overflow_down();
        trap_wrap_clean();
        trap_negative_sum();
        zero_register();
        ignore_case();
        close_out();
    end
endmodule
bind word_adder_overflow_trap word_adder_assertions chk_i (.*);
`default_nettype wire
